// [core/uart_chan_regs.svh]
// Register offsets, field positions, reset values and keys of one channel
`ifndef UART_CHAN_REGS_SVH
`define UART_CHAN_REGS_SVH

// Offsets on the three address lines
`define OFS_DATA         3'h0
`define OFS_MASK         3'h1
`define OFS_SOURCE       3'h2
`define OFS_LINE_CTRL    3'h3
`define OFS_LINE_STAT    3'h5
`define OFS_RESUME_1     3'h4
`define OFS_RESUME_2     3'h5
`define OFS_PAUSE_1      3'h6
`define OFS_PAUSE_2      3'h7

// Line-control value that opens the enhanced bank
`define ENH_KEY          8'hBF
`define LCR_DLAB_BIT     7

// Field positions
`define FCR_FIFO_EN_BIT  0
`define IER_RX_BIT       0
`define IER_TX_BIT       1
`define IER_LINE_BIT     2
`define IER_MODEM_BIT    3
`define EFR_ENH_BIT      4
`define ISR_NONE_BIT     0

// Reset values
`define RST_BYTE         8'h00
`define RST_LCR          8'h00
`define RST_IER          8'h00
`define RST_DIV          16'h0000

// Oversampling of the baud generator and timeout figures
`define BAUD_OVERSAMPLE  16
`define TMO_CHARS        4
`define TMO_EXTRA_BITS   12

`endif

// [core/uart_chan_pkg.sv]
// Types shared by the channel register bank
package uart_chan_pkg;

   typedef logic [7:0]  byte_t;
   typedef logic [15:0] div_t;

   // Interrupt source codes, in priority order
   typedef enum logic [5:0] {
      SRC_LINE    = 6'h06,
      SRC_TIMEOUT = 6'h0C,
      SRC_RXDATA  = 6'h04,
      SRC_TXRDY   = 6'h02,
      SRC_MODEM   = 6'h00,
      SRC_NONE    = 6'h01
   } isr_code_t;

endpackage

// [core/baud_tick.sv]
// Bit-time enable pulse from the programmed divisor
`timescale 1ns/1ps
module baud_tick #(
   parameter int DIV_W = 16,
   parameter int OVS   = 16
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   input  wire logic [DIV_W-1:0] i_divisor,
   output logic                  o_tick
);
   localparam int CW = DIV_W + $clog2(OVS);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          tick_reg;
   logic          tick_next;
   logic [CW-1:0] limit;

   always_comb begin
      limit     = CW'(i_divisor) * CW'(OVS);
      cnt_next  = cnt_reg + 1'b1;
      tick_next = 1'b0;
      // A zero divisor stops the generator
      if (i_divisor == '0) begin
         cnt_next = '0;
      end else if (cnt_next >= limit) begin
         cnt_next  = '0;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign o_tick = tick_reg;
endmodule

// [core/rx_timeout.sv]
// Receive idle timer counted in bit times
`timescale 1ns/1ps
module rx_timeout #(
   parameter int LIM_W = 8
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst,
   input  wire logic             i_tick,
   input  wire logic             i_armed,
   input  wire logic             i_activity,
   input  wire logic             i_clear,
   input  wire logic [LIM_W-1:0] i_limit,
   output logic                  o_expired
);
   logic [LIM_W-1:0] cnt_reg;
   logic [LIM_W-1:0] cnt_next;
   logic             exp_reg;
   logic             exp_next;

   always_comb begin
      cnt_next = cnt_reg;
      exp_next = exp_reg;
      if (!i_armed || i_activity) begin
         cnt_next = '0;
      end else if (i_tick && cnt_reg != i_limit) begin
         cnt_next = cnt_reg + 1'b1;
      end
      // Expiry holds until the holding register is read or the timer is disarmed
      if (i_armed && i_tick && !i_activity
          && cnt_reg + 1'b1 == i_limit) begin
         exp_next = 1'b1;
      end else if (i_clear || !i_armed) begin
         exp_next = 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         cnt_reg <= '0;
         exp_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         exp_reg <= exp_next;
      end
   end

   assign o_expired = exp_reg;
endmodule

// [core/uart_chan_regs.sv]
// Per-channel register bank of a quad UART
`timescale 1ns/1ps
`include "uart_chan_regs.svh"
module uart_chan_regs #(
   parameter int          FIFO_DEPTH = 128,
   parameter int          CNT_W      = 8,
   parameter logic [7:0]  TRIG_0     = 8'h01,
   parameter logic [7:0]  TRIG_1     = 8'h04,
   parameter logic [7:0]  TRIG_2     = 8'h08,
   parameter logic [7:0]  TRIG_3     = 8'h0E,
   // Identity bytes: arbitrary values
   parameter logic [7:0]  REV_ID     = 8'h01,
   parameter logic [7:0]  DEV_ID     = 8'h5A
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_cs,
   input  wire logic        i_rd,
   input  wire logic        i_wr,
   input  wire logic [2:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_fifo_status_select_n,
   input  wire logic        i_rx_push,
   input  wire logic [7:0]  i_rx_data,
   input  wire logic [6:0]  i_line_flags,
   input  wire logic        i_tx_ready,
   input  wire logic        i_modem_change,
   input  wire logic [2:0]  i_peer_rx_ready_n,
   input  wire logic [2:0]  i_peer_tx_ready_n,
   output logic [7:0]       o_rdata,
   output logic             o_irq,
   output logic             o_rx_pop,
   output logic             o_tx_wr,
   output logic [7:0]       o_tx_data,
   output logic [15:0]      o_divisor,
   output logic [7:0]       o_line_control,
   output logic [7:0]       o_feature_control,
   output logic [7:0]       o_enh_ctrl,
   output logic [31:0]      o_flow_chars,
   output logic             o_bit_tick
);
   uart_chan_pkg::byte_t     lcr_reg, lcr_next;
   uart_chan_pkg::byte_t     ier_reg, ier_next;
   uart_chan_pkg::byte_t     fcr_reg, fcr_next;
   uart_chan_pkg::byte_t     efr_reg, efr_next;
   uart_chan_pkg::byte_t     feature_control_reg, feature_control_next;
   uart_chan_pkg::byte_t     trg_reg, trg_next;
   uart_chan_pkg::div_t      div_reg, div_next;
   logic [31:0]              flow_reg, flow_next;
   logic [CNT_W-1:0]         cnt_reg, cnt_next;
   logic                     ready_reg, ready_next;
   logic                     txp_reg, txp_next;
   logic                     txd_reg, txd_next;
   uart_chan_pkg::byte_t     rdata_reg, rdata_next;
   logic                     irq_reg, irq_next;
   logic                     pop_reg, pop_next;
   logic                     twr_reg, twr_next;
   uart_chan_pkg::byte_t     tdat_reg, tdat_next;

   logic                     sel_rd, sel_wr, enh, dlab, div_zero;
   logic                     push, pop, rhr_rd, isr_rd;
   logic                     fifo_on, rx_lvl, tmo;
   logic [7:0]               trig, tmo_lim, char_bits;
   uart_chan_pkg::isr_code_t src;
   uart_chan_pkg::byte_t     isr_val, lsr_val, shared_fifo_ready_status_val;

   baud_tick #(
      .DIV_W (16),
      .OVS   (`BAUD_OVERSAMPLE)
   ) u_baud (
      .i_mclk    (i_mclk),
      .i_rst     (i_rst),
      .i_divisor (div_reg),
      .o_tick    (o_bit_tick)
   );

   rx_timeout #(
      .LIM_W (8)
   ) u_tmo (
      .i_mclk     (i_mclk),
      .i_rst      (i_rst),
      .i_tick     (o_bit_tick),
      .i_armed    (fifo_on && cnt_reg != '0),
      .i_activity (push || pop),
      .i_clear    (rhr_rd),
      .i_limit    (tmo_lim),
      .o_expired  (tmo)
   );

   // Decode, status and interrupt source
   always_comb begin
      sel_rd   = i_cs && i_rd;
      sel_wr   = i_cs && i_wr;
      enh      = lcr_reg == `ENH_KEY;
      dlab     = lcr_reg[`LCR_DLAB_BIT] && !enh;
      div_zero = div_reg == '0;
      fifo_on  = fcr_reg[`FCR_FIFO_EN_BIT];
      rhr_rd   = sel_rd && i_fifo_status_select_n && !enh && !dlab
                 && i_addr == `OFS_DATA;
      isr_rd   = sel_rd && i_fifo_status_select_n && !enh && !dlab
                 && i_addr == `OFS_SOURCE;
      push     = i_rx_push && cnt_reg < CNT_W'(FIFO_DEPTH);
      pop      = rhr_rd && cnt_reg != '0;
      if (feature_control_reg[5:4] == 2'b11) begin
         trig = trg_reg;
      end else if (fcr_reg[7:6] == 2'b00) begin
         trig = TRIG_0;
      end else if (fcr_reg[7:6] == 2'b01) begin
         trig = TRIG_1;
      end else if (fcr_reg[7:6] == 2'b10) begin
         trig = TRIG_2;
      end else begin
         trig = TRIG_3;
      end
      // Start, data, parity and stop bits of one character
      char_bits = 8'(1 + 5 + lcr_reg[1:0] + lcr_reg[3] + 1 + lcr_reg[2]);
      tmo_lim   = 8'(`TMO_CHARS * char_bits + `TMO_EXTRA_BITS);
      // FIFO mode waits for the trigger, otherwise any character
      rx_lvl = fifo_on ? (8'(cnt_reg) >= trig) : (cnt_reg != '0);
      src = uart_chan_pkg::SRC_NONE;
      if (ier_reg[`IER_LINE_BIT] && |i_line_flags[3:0]) begin
         src = uart_chan_pkg::SRC_LINE;
      end else if (ier_reg[`IER_RX_BIT] && fifo_on && tmo) begin
         src = uart_chan_pkg::SRC_TIMEOUT;
      end else if (ier_reg[`IER_RX_BIT] && rx_lvl) begin
         src = uart_chan_pkg::SRC_RXDATA;
      end else if (ier_reg[`IER_TX_BIT] && txp_reg) begin
         src = uart_chan_pkg::SRC_TXRDY;
      end else if (ier_reg[`IER_MODEM_BIT] && i_modem_change) begin
         src = uart_chan_pkg::SRC_MODEM;
      end
      isr_val   = {fifo_on, fifo_on, src};
      lsr_val   = {i_line_flags, ready_reg};
      shared_fifo_ready_status_val = {i_peer_rx_ready_n, !ready_reg,
                   i_peer_tx_ready_n, !i_tx_ready};
   end

   // Register writes and the transmit write strobe
   always_comb begin
      lcr_next  = lcr_reg;
      ier_next  = ier_reg;
      fcr_next  = fcr_reg;
      efr_next  = efr_reg;
      feature_control_next = feature_control_reg;
      trg_next  = trg_reg;
      div_next  = div_reg;
      flow_next = flow_reg;
      tdat_next = tdat_reg;
      twr_next  = 1'b0;
      if (sel_wr && i_addr == `OFS_LINE_CTRL) begin
         lcr_next = i_wdata;
      end else if (sel_wr && enh) begin
         if (i_addr == `OFS_DATA) begin
            trg_next = i_wdata;
         end else if (i_addr == `OFS_MASK) begin
            feature_control_next = i_wdata;
         end else if (i_addr == `OFS_SOURCE) begin
            efr_next = i_wdata;
         end else if (i_addr == `OFS_RESUME_1) begin
            flow_next[7:0] = i_wdata;
         end else if (i_addr == `OFS_RESUME_2) begin
            flow_next[15:8] = i_wdata;
         end else if (i_addr == `OFS_PAUSE_1) begin
            flow_next[23:16] = i_wdata;
         end else if (i_addr == `OFS_PAUSE_2) begin
            flow_next[31:24] = i_wdata;
         end
      end else if (sel_wr && dlab && i_addr == `OFS_DATA) begin
         div_next[7:0] = i_wdata;
      end else if (sel_wr && dlab && i_addr == `OFS_MASK) begin
         div_next[15:8] = i_wdata;
      end else if (sel_wr && i_addr == `OFS_DATA) begin
         tdat_next = i_wdata;
         twr_next  = 1'b1;
      end else if (sel_wr && i_addr == `OFS_MASK) begin
         // Upper enables need the enhanced-function bit
         ier_next[3:0] = i_wdata[3:0];
         if (efr_reg[`EFR_ENH_BIT]) begin
            ier_next[7:4] = i_wdata[7:4];
         end
      end else if (sel_wr && i_addr == `OFS_SOURCE) begin
         // Bits 7:3 only take effect with the enable bit set; bits 2:1 are never stored
         fcr_next[`FCR_FIFO_EN_BIT] = i_wdata[`FCR_FIFO_EN_BIT];
         if (i_wdata[`FCR_FIFO_EN_BIT]) begin
            fcr_next[7:3] = i_wdata[7:3];
         end
      end
   end

   // Read data, FIFO count and pending flags
   always_comb begin
      rdata_next = rdata_reg;
      cnt_next   = CNT_W'(cnt_reg + CNT_W'(push) - CNT_W'(pop));
      ready_next = cnt_next != '0;
      pop_next   = pop;
      txd_next   = i_tx_ready;
      txp_next   = txp_reg;
      if (isr_rd && src == uart_chan_pkg::SRC_TXRDY) begin
         txp_next = 1'b0;
      end else if (twr_next) begin
         txp_next = 1'b0;
      end
      if (i_tx_ready && !txd_reg) begin
         txp_next = 1'b1;
      end
      irq_next = !isr_val[`ISR_NONE_BIT];
      if (sel_rd) begin
         rdata_next = 8'h00;
         if (!i_fifo_status_select_n) begin
            rdata_next = shared_fifo_ready_status_val;
         end else if (i_addr == `OFS_LINE_CTRL) begin
            rdata_next = lcr_reg;
         end else if (enh) begin
            if (i_addr == `OFS_DATA) begin
               rdata_next = 8'(cnt_reg);
            end else if (i_addr == `OFS_MASK) begin
               rdata_next = feature_control_reg;
            end else if (i_addr == `OFS_SOURCE) begin
               rdata_next = efr_reg;
            end else if (i_addr == `OFS_RESUME_1) begin
               rdata_next = flow_reg[7:0];
            end else if (i_addr == `OFS_RESUME_2) begin
               rdata_next = flow_reg[15:8];
            end else if (i_addr == `OFS_PAUSE_1) begin
               rdata_next = flow_reg[23:16];
            end else if (i_addr == `OFS_PAUSE_2) begin
               rdata_next = flow_reg[31:24];
            end
         end else if (dlab && i_addr == `OFS_DATA) begin
            rdata_next = div_zero ? REV_ID : div_reg[7:0];
         end else if (dlab && i_addr == `OFS_MASK) begin
            rdata_next = div_zero ? DEV_ID : div_reg[15:8];
         end else if (dlab) begin
            rdata_next = 8'h00;
         end else if (i_addr == `OFS_DATA) begin
            rdata_next = i_rx_data;
         end else if (i_addr == `OFS_MASK) begin
            rdata_next = ier_reg;
         end else if (i_addr == `OFS_SOURCE) begin
            rdata_next = isr_val;
         end else if (i_addr == `OFS_LINE_STAT) begin
            rdata_next = lsr_val;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         lcr_reg   <= `RST_LCR;
         ier_reg   <= `RST_IER;
         fcr_reg   <= `RST_BYTE;
         efr_reg   <= `RST_BYTE;
         feature_control_reg  <= `RST_BYTE;
         trg_reg   <= `RST_BYTE;
         div_reg   <= `RST_DIV;
         flow_reg  <= '0;
         cnt_reg   <= '0;
         ready_reg <= 1'b0;
         txp_reg   <= 1'b0;
         txd_reg   <= 1'b0;
         rdata_reg <= `RST_BYTE;
         irq_reg   <= 1'b0;
         pop_reg   <= 1'b0;
         twr_reg   <= 1'b0;
         tdat_reg  <= `RST_BYTE;
      end else begin
         lcr_reg   <= lcr_next;
         ier_reg   <= ier_next;
         fcr_reg   <= fcr_next;
         efr_reg   <= efr_next;
         feature_control_reg  <= feature_control_next;
         trg_reg   <= trg_next;
         div_reg   <= div_next;
         flow_reg  <= flow_next;
         cnt_reg   <= cnt_next;
         ready_reg <= ready_next;
         txp_reg   <= txp_next;
         txd_reg   <= txd_next;
         rdata_reg <= rdata_next;
         irq_reg   <= irq_next;
         pop_reg   <= pop_next;
         twr_reg   <= twr_next;
         tdat_reg  <= tdat_next;
      end
   end

   assign o_rdata           = rdata_reg;
   assign o_irq             = irq_reg;
   assign o_rx_pop          = pop_reg;
   assign o_tx_wr           = twr_reg;
   assign o_tx_data         = tdat_reg;
   assign o_divisor         = div_reg;
   assign o_line_control    = lcr_reg;
   assign o_feature_control = feature_control_reg;
   assign o_enh_ctrl        = efr_reg;
   assign o_flow_chars      = flow_reg;
endmodule

// [tb/uart_chan_regs_asserts.sv]
// Port-level checks of the channel register bank
`timescale 1ns/1ps
module uart_chan_regs_asserts #(
   parameter logic [7:0] REV_ID = 8'h01,
   parameter logic [7:0] DEV_ID = 8'h5A
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_cs,
   input  wire logic        i_rd,
   input  wire logic        i_wr,
   input  wire logic [2:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_fifo_status_select_n,
   input  wire logic        i_tx_ready,
   input  wire logic [2:0]  i_peer_rx_ready_n,
   input  wire logic [2:0]  i_peer_tx_ready_n,
   input  wire logic [7:0]  o_rdata,
   input  wire logic        o_irq,
   input  wire logic [15:0] o_divisor,
   input  wire logic [7:0]  o_line_control
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   logic rd_q;
   logic wr_q;
   logic div_sel;
   assign rd_q    = i_cs && i_rd && i_fifo_status_select_n;
   assign wr_q    = i_cs && i_wr;
   assign div_sel = o_line_control[7] && (o_line_control != 8'hBF);

   a_boot_irq_low: assert property ($fell(i_rst) |-> !o_irq [*2])
      else $error("interrupt raised right after reset");
   a_boot_quiet: assert property ($fell(i_rst) |-> o_rdata == 8'h00)
      else $error("read data not cleared by reset");
   a_div_high_write: assert property (wr_q && i_addr == 3'h1 && div_sel
      |=> o_divisor[15:8] == $past(i_wdata))
      else $error("divisor high byte not written");
   a_div_key_hold: assert property (wr_q && !div_sel && i_addr[2:1] == 2'b00
      |=> $stable(o_divisor))
      else $error("divisor changed outside the latch window");
   a_div_read_back: assert property (rd_q && i_addr == 3'h0 && div_sel
      && o_divisor != 16'h0000 |=> o_rdata == o_divisor[7:0])
      else $error("divisor low byte read wrong");
   a_ident_rev_read: assert property (rd_q && i_addr == 3'h0 && div_sel
      && o_divisor == 16'h0000 |=> o_rdata == REV_ID)
      else $error("revision byte not returned");
   a_ident_dev_read: assert property (rd_q && i_addr == 3'h1 && div_sel
      && o_divisor == 16'h0000 |=> o_rdata == DEV_ID)
      else $error("device byte not returned");
   a_isr_irq_agree: assert property (rd_q && i_addr == 3'h2
      && !o_line_control[7] |=> o_rdata[0] == !o_irq)
      else $error("status bit 0 disagrees with interrupt");
   a_shared_fifo_ready_status_bits: assert property (i_cs && i_rd && !i_fifo_status_select_n
      |=> o_rdata[7:5] == $past(i_peer_rx_ready_n)
      && o_rdata[3:1] == $past(i_peer_tx_ready_n)
      && o_rdata[0] == !$past(i_tx_ready))
      else $error("fifo status byte wrong");

   c_irq_seen: cover property (rd_q && i_addr == 3'h2 ##1 o_irq);
   c_div_write: cover property (wr_q && div_sel);
   c_shared_fifo_ready_status_read: cover property (i_cs && i_rd && !i_fifo_status_select_n);
endmodule

// [tb/host_bus.sv]
// Host processor model on the parallel register bus
`timescale 1ns/1ps
module host_bus (
   input  wire logic       i_mclk,
   input  wire logic [7:0] i_rdata,
   output logic            o_cs,
   output logic            o_rd,
   output logic            o_wr,
   output logic [2:0]      o_addr,
   output logic [7:0]      o_wdata,
   output logic            o_fsel_n
);
   initial begin
      o_cs = 1'b0;
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_addr = 3'h0;
      o_wdata = 8'h00;
      o_fsel_n = 1'b1;
   end

   // One access: held over one taking edge, then released
   task automatic access(input logic w, input logic [2:0] a,
                         input logic [7:0] d, input logic s_n,
                         output logic [7:0] q);
      @(posedge i_mclk);
      #1;
      o_cs = 1'b1;
      o_rd = !w;
      o_wr = w;
      o_addr = a;
      o_wdata = d;
      o_fsel_n = s_n;
      @(posedge i_mclk);
      #1;
      o_cs = 1'b0;
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
      o_fsel_n = 1'b1;
      q = i_rdata;
   endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the channel register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      fails++; \
      $display("BAD %0t got %h exp %h", $time, (got), (exp)); \
   end \
end
module testbench;
   // Identity bytes: arbitrary values
   localparam logic [7:0] REV  = 8'h01;
   localparam logic [7:0] DEV  = 8'h5A;
   localparam logic [7:0] TRIG = 8'h04;
   logic        i_mclk = 1'b0;
   logic        i_rst = 1'b1;
   logic        cs, rd_s, wr_s, fsel_n, irq, rx_pop;
   logic [2:0]  addr;
   logic [7:0]  wdata, rdata, q;
   logic        rx_push = 1'b0;
   logic [7:0]  rx_data = 8'h00;
   logic [6:0]  line_flags = 7'h00;
   logic        tx_ready = 1'b0;
   logic        modem = 1'b0;
   logic [2:0]  peer_rx_n = 3'h7;
   logic [2:0]  peer_tx_n = 3'h7;
   logic [15:0] dv, divisor;
   logic        tx_wr;
   logic [7:0]  tx_data, lcr_out;
   logic [31:0] flow;
   logic [7:0]  codes [4] = '{8'hC1, 8'hC2, 8'hC6, 8'hC0};
   int          fails = 0;
   int          n_tests = 0;
   int          n;

   always #5 i_mclk = ~i_mclk;

   host_bus host (.i_mclk(i_mclk), .i_rdata(rdata), .o_cs(cs),
      .o_rd(rd_s), .o_wr(wr_s), .o_addr(addr), .o_wdata(wdata),
      .o_fsel_n(fsel_n));

   uart_chan_regs #(.TRIG_1(TRIG), .REV_ID(REV), .DEV_ID(DEV)) uut (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_cs(cs), .i_rd(rd_s),
      .i_wr(wr_s), .i_addr(addr), .i_wdata(wdata),
      .i_fifo_status_select_n(fsel_n), .i_rx_push(rx_push),
      .i_rx_data(rx_data), .i_line_flags(line_flags),
      .i_tx_ready(tx_ready), .i_modem_change(modem),
      .i_peer_rx_ready_n(peer_rx_n), .i_peer_tx_ready_n(peer_tx_n),
      .o_rdata(rdata), .o_irq(irq), .o_rx_pop(rx_pop),
      .o_tx_wr(tx_wr), .o_tx_data(tx_data), .o_divisor(divisor),
      .o_line_control(lcr_out), .o_feature_control(), .o_enh_ctrl(),
      .o_flow_chars(flow),
      .o_bit_tick());

   function automatic logic [7:0] exp_isr(input int cnt);
      return (cnt >= int'(TRIG)) ? 8'hC4 : 8'hC1;
   endfunction

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] unused;
      host.access(1'b1, a, d, 1'b1, unused);
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      host.access(1'b0, a, 8'($urandom), 1'b1, d);
   endtask

   task automatic push(input int cnt);
      rx_push = 1'b1;
      repeat (cnt) @(posedge i_mclk);
      #1 rx_push = 1'b0;
   endtask

   task automatic reset_check();
      rd(3'h1, q);
      `CHK(q, 8'h00)
      rd(3'h2, q);
      `CHK(q, 8'h01)
      `CHK(irq, 1'b0)
      rd(3'h5, q);
      `CHK(q[0], 1'b0)
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #300_000;
      fails++;
      end_of_test();
   end

   initial begin
      void'($urandom(41488));
      repeat (12) @(posedge i_mclk);
      #1 i_rst = 1'b0;
      reset_check();
      // Divisor latch window, then hidden behind the key
      wr(3'h3, 8'h80);
      dv = 16'($urandom_range(1, 65535));
      wr(3'h0, dv[7:0]);
      wr(3'h1, dv[15:8]);
      rd(3'h1, q);
      `CHK(q, dv[15:8])
      wr(3'h3, 8'hBF);
      `CHK(lcr_out, 8'hBF)
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      `CHK(divisor, dv)
      wr(3'h4, 8'h3C);
      `CHK(flow[7:0], 8'h3C)
      rd(3'h4, q);
      `CHK(q, 8'h3C)
      wr(3'h3, 8'h80);
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      rd(3'h0, q);
      `CHK(q, REV)
      rd(3'h1, q);
      `CHK(q, DEV)
      // Receive FIFO fill and drain around the trigger level
      wr(3'h3, 8'h00);
      wr(3'h2, 8'h41);
      wr(3'h1, 8'h01);
      for (int t = 0; t < 5; t++) begin
         n = (t < 2) ? 4 - t : $urandom_range(1, 7);
         rx_data = 8'($urandom);
         push(n);
         rd(3'h5, q);
         `CHK(q, 8'h01)
         rd(3'h2, q);
         `CHK(q, exp_isr(n))
         `CHK(irq, 1'(n >= int'(TRIG)))
         for (int k = 1; k <= n; k++) begin
            rd(3'h0, q);
            `CHK(rx_pop, 1'b1)
            rd(3'h2, q);
            `CHK(q, exp_isr(n - k))
            rd(3'h5, q);
            `CHK(q[0], 1'(k < n))
         end
      end
      // Each mask bit alone with the line, transmit and modem sources raised
      line_flags = 7'h01;
      modem = 1'b1;
      tx_ready = 1'b1;
      for (int k = 0; k < 4; k++) begin
         wr(3'h1, 8'(1 << k));
         rd(3'h2, q);
         `CHK(q, codes[k])
         `CHK(irq, 1'(codes[k] != 8'hC1))
      end
      wr(3'h1, 8'h00);
      rd(3'h2, q);
      `CHK(q, 8'hC1)
      wr(3'h0, 8'hA5);
      `CHK(tx_wr, 1'b1)
      `CHK(tx_data, 8'hA5)
      line_flags = 7'h00;
      modem = 1'b0;
      // Idle timeout: 40 bit times of 16 clocks at divisor 1
      wr(3'h3, 8'h80);
      wr(3'h0, 8'h01);
      wr(3'h3, 8'h00);
      wr(3'h1, 8'h01);
      push(1);
      repeat (600) @(posedge i_mclk);
      rd(3'h2, q);
      `CHK(q, 8'hC1)
      repeat (100) @(posedge i_mclk);
      rd(3'h2, q);
      `CHK(q, 8'hCC)
      rd(3'h0, q);
      rd(3'h2, q);
      `CHK(q, 8'hC1)
      peer_rx_n = 3'($urandom);
      peer_tx_n = 3'($urandom);
      host.access(1'b0, 3'($urandom), 8'h00, 1'b0, q);
      // Second reset in mid-run
      i_rst = 1'b1;
      repeat (2) @(posedge i_mclk);
      #1 i_rst = 1'b0;
      reset_check();
      end_of_test();
   end
endmodule

bind uart_chan_regs uart_chan_regs_asserts #(
   .REV_ID(REV_ID),
   .DEV_ID(DEV_ID)
) chk (
   .i_mclk, .i_rst, .i_cs, .i_rd, .i_wr, .i_addr, .i_wdata,
   .i_fifo_status_select_n, .i_tx_ready, .i_peer_rx_ready_n,
   .i_peer_tx_ready_n, .o_rdata, .o_irq, .o_divisor, .o_line_control
);
